// file: design/mfsd_device.sv
// Purpose: Device end, memory selects with fixed priority and space mapping
// Assumes: Bus strobes come from logic on clk_i, so no synchroniser
// Notes:   Selects and read data are registered one cycle after the strobe
//
// Function
// - Selects come from configured address decode array
// - Sector select range never exceeds sector size
// - Main flash sector ranges never overlap
// - Secondary flash sector ranges never overlap
// - SRAM, register, peripheral ranges never overlap
// - Secondary flash beats overlapping main flash
// - SRAM or register space beats any flash
// - Three priority levels, level one highest
// - Map bits 4,3 gate data reads
// - Map bits 2,1,0 gate program fetches
// - Software writes zero to map bits 7-5
// - Map starts configured, rewrites act immediately
// - Separate spaces use map value 0Ch
// - Combined main flash needs bits 2,4
`timescale 1ns/100ps
module mfsd_device (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  mfsd_bus_if.device                 bus,
  input  wire logic [7:0]            mem_rdata_i,
  output logic [mfsd_pkg::MAIN_COUNT-1:0] main_flash_sector_select_o,
  output logic [mfsd_pkg::SEC_COUNT-1:0]  secondary_flash_sector_select_o,
  output logic                       sram_select_o,
  output logic                       control_register_space_select_o,
  output logic [7:0]                 memory_space_map_o
);
  import mfsd_pkg::*;

  typedef struct packed {
    logic [MAP_USED_W-1:0] map;
    logic [MAIN_COUNT-1:0] main_sel;
    logic [SEC_COUNT-1:0]  sec_sel;
    logic                  sram_sel;
    logic                  ctrl_sel;
    logic [7:0]            rdata;
    logic                  rdata_oe;
  } mfsd_dev_state_type;

  mfsd_dev_state_type r;
  mfsd_dev_state_type next_r;

  logic [MAIN_COUNT-1:0] main_hit;
  logic [SEC_COUNT-1:0]  sec_hit;
  logic                  sram_hit;
  logic                  ctrl_hit;
  logic                  fetch;
  logic                  rd;
  logic                  wr;
  logic                  level1;
  logic [MAIN_COUNT-1:0] main_win;
  logic [SEC_COUNT-1:0]  sec_win;
  logic                  main_ok;
  logic                  sec_ok;
  logic                  sram_ok;
  logic                  ctrl_ok;
  logic                  map_hit;

  // Address decode array, one compare per select
  genvar gi;
  generate
    for (gi = 0; gi < MAIN_COUNT; gi++)
    begin : g_main
      mfsd_range_match #(
        .LOW  (16'(MAIN_LOW0 + gi * MAIN_SPAN)),
        .HIGH (16'(MAIN_LOW0 + (gi + 1) * MAIN_SPAN - 1))
      ) u_match (
        .addr_i (bus.addr),
        .hit_o  (main_hit[gi])
      );
    end
    for (gi = 0; gi < SEC_COUNT; gi++)
    begin : g_sec
      mfsd_range_match #(
        .LOW  (16'(SEC_LOW0 + gi * SEC_SPAN)),
        .HIGH (16'(SEC_LOW0 + (gi + 1) * SEC_SPAN - 1))
      ) u_match (
        .addr_i (bus.addr),
        .hit_o  (sec_hit[gi])
      );
    end
  endgenerate

  mfsd_range_match #(
    .LOW  (SRAM_LOW),
    .HIGH (SRAM_HIGH)
  ) u_sram (
    .addr_i (bus.addr),
    .hit_o  (sram_hit)
  );

  mfsd_range_match #(
    .LOW  (CTRL_LOW),
    .HIGH (CTRL_HIGH)
  ) u_ctrl (
    .addr_i (bus.addr),
    .hit_o  (ctrl_hit)
  );

  always_comb
  begin
    fetch   = !bus.psen_n;
    rd      = !bus.rd_n;
    wr      = !bus.wr_n;
    map_hit = ctrl_hit && (bus.addr == MAP_ADDR);

    // Level one: SRAM and register space; level two: secondary; level three: main
    level1   = sram_hit || ctrl_hit;
    sec_win  = level1 ? '0 : sec_hit;
    main_win = (level1 || (|sec_hit)) ? '0 : main_hit;

    // Priority uses the raw decode, so a denied winner still masks lower levels
    main_ok = (fetch && r.map[MAP_MAIN_FLASH_IN_CODE_SPACE]) || ((rd || wr) && r.map[MAP_MAIN_FLASH_IN_DATA_SPACE]);
    sec_ok  = (fetch && r.map[MAP_SEC_CODE]) || ((rd || wr) && r.map[MAP_SEC_DATA]);
    sram_ok = (fetch && r.map[MAP_SRAM_CODE]) || rd || wr;
    ctrl_ok = rd || wr;

    next_r          = r;
    next_r.main_sel = main_ok ? main_win : '0;
    next_r.sec_sel  = sec_ok ? sec_win : '0;
    next_r.sram_sel = sram_ok && sram_hit;
    next_r.ctrl_sel = ctrl_ok && ctrl_hit;

    // New mapping steers the very next bus cycle
    if (wr && map_hit)
    begin
      next_r.map = bus.data_bus[MAP_USED_W-1:0];
    end

    next_r.rdata    = DATA_ZERO;
    next_r.rdata_oe = 1'b0;
    if (rd && ctrl_hit)
    begin
      next_r.rdata    = map_hit ? {3'b000, r.map} : DATA_ZERO;
      next_r.rdata_oe = 1'b1;
    end
    else if ((fetch || rd) &&
             ((|next_r.main_sel) || (|next_r.sec_sel) || next_r.sram_sel))
    begin
      next_r.rdata    = mem_rdata_i;
      next_r.rdata_oe = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      r.map      <= MAP_RESET[MAP_USED_W-1:0];
      r.main_sel <= '0;
      r.sec_sel  <= '0;
      r.sram_sel <= 1'b0;
      r.ctrl_sel <= 1'b0;
      r.rdata    <= DATA_ZERO;
      r.rdata_oe <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign main_flash_sector_select_o      = r.main_sel;
  assign secondary_flash_sector_select_o = r.sec_sel;
  assign sram_select_o                   = r.sram_sel;
  assign control_register_space_select_o = r.ctrl_sel;
  assign memory_space_map_o              = {3'b000, r.map};
  assign bus.dev_data                    = r.rdata;
  assign bus.dev_data_oe                 = r.rdata_oe;

endmodule // mfsd_device

// file: common/mfsd_pkg.sv
// Purpose: Shared constants and types for the memory select priority decoder
// Assumes: One 100 MHz clock shared by both ends
// Notes:   Decode ranges stand for the configured select equations
package mfsd_pkg;

  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 8;
  localparam int MAIN_COUNT = 8;
  localparam int SEC_COUNT  = 4;

  // Configured decode ranges (inclusive bounds)
  localparam logic [15:0] MAIN_LOW0 = 16'h0000;
  localparam logic [15:0] MAIN_SPAN = 16'h2000;
  localparam logic [15:0] SEC_LOW0  = 16'h8000;
  localparam logic [15:0] SEC_SPAN  = 16'h0800;
  localparam logic [15:0] SRAM_LOW  = 16'h2000;
  localparam logic [15:0] SRAM_HIGH = 16'h27ff;
  localparam logic [15:0] CTRL_LOW  = 16'hff00;
  localparam logic [15:0] CTRL_HIGH = 16'hffff;

  // Mapping register location inside the control-register space
  localparam logic [15:0] MAP_ADDR  = 16'hffc2;

  // Mapping register layout and start-up value
  localparam logic [7:0] MAP_RESET     = 8'h0c;
  localparam int         MAP_USED_W    = 5;
  localparam int         MAP_MAIN_FLASH_IN_DATA_SPACE   = 4;
  localparam int         MAP_SEC_DATA  = 3;
  localparam int         MAP_MAIN_FLASH_IN_CODE_SPACE   = 2;
  localparam int         MAP_SEC_CODE  = 1;
  localparam int         MAP_SRAM_CODE = 0;

  // Level of the shared data wire when nobody drives it
  localparam logic [7:0] DATA_IDLE  = 8'hff;
  localparam logic [7:0] DATA_ZERO  = 8'h00;

  typedef enum logic [1:0] {
    MFSD_KIND_FETCH = 2'b00,
    MFSD_KIND_READ  = 2'b01,
    MFSD_KIND_WRITE = 2'b10
  } mfsd_kind_type;

  typedef enum logic [1:0] {
    MFSD_HST_IDLE   = 2'b00,
    MFSD_HST_DRIVE  = 2'b01,
    MFSD_HST_SAMPLE = 2'b10,
    MFSD_HST_FINISH = 2'b11
  } mfsd_host_state_type;

endpackage

// file: common/mfsd_bus_if.sv
// Purpose: Microcontroller bus between the host end and the device end
// Assumes: Active-low strobes, one strobe at a time
// Notes:   The shared data wire is resolved here from the two enables
`timescale 1ns/100ps
interface mfsd_bus_if;
  import mfsd_pkg::*;

  logic [15:0] addr;
  logic        psen_n;
  logic        rd_n;
  logic        wr_n;
  logic [7:0]  host_data;
  logic        host_data_oe;
  logic [7:0]  dev_data;
  logic        dev_data_oe;
  logic [7:0]  data_bus;

  // Host wins a clash; an undriven wire floats high
  assign data_bus = host_data_oe ? host_data : (dev_data_oe ? dev_data : DATA_IDLE);

  modport host (
    output addr,
    output psen_n,
    output rd_n,
    output wr_n,
    output host_data,
    output host_data_oe,
    input  data_bus,
    input  dev_data_oe
  );

  modport device (
    input  addr,
    input  psen_n,
    input  rd_n,
    input  wr_n,
    input  data_bus,
    output dev_data,
    output dev_data_oe
  );

endinterface

// file: design/mfsd_range_match.sv
// Purpose: One product-term style address range compare
// Assumes: LOW not above HIGH
// Notes:   Purely combinational
`timescale 1ns/100ps
module mfsd_range_match #(
  parameter logic [15:0] LOW  = 16'h0000,
  parameter logic [15:0] HIGH = 16'hffff
) (
  input  wire logic [15:0] addr_i,
  output logic             hit_o
);
  import mfsd_pkg::*;

  assign hit_o = (addr_i >= LOW) && (addr_i <= HIGH);

endmodule // mfsd_range_match

// file: design/mfsd_host.sv
// Purpose: Host end, runs one fetch, read or write cycle per request
// Assumes: Device answers in the cycle after the strobe first shows
// Notes:   Strobe stands two cycles, data is sampled at the end of the second
`timescale 1ns/100ps
module mfsd_host (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  mfsd_bus_if.host                     bus,
  input  wire logic                    req_i,
  input  wire mfsd_pkg::mfsd_kind_type req_kind_i,
  input  wire logic [15:0]             req_addr_i,
  input  wire logic [7:0]              req_wdata_i,
  output logic                         ready_o,
  output logic                         done_o,
  output logic [7:0]                   rdata_o,
  output logic                         answered_o
);
  import mfsd_pkg::*;

  typedef struct packed {
    mfsd_host_state_type state;
    mfsd_kind_type       kind;
    logic [15:0]         addr;
    logic [7:0]          wdata;
    logic [7:0]          rdata;
    logic                answered;
    logic                done;
  } mfsd_host_reg_type;

  mfsd_host_reg_type r;
  mfsd_host_reg_type next_r;
  logic              active;

  always_comb
  begin
    next_r      = r;
    next_r.done = 1'b0;
    case (r.state)
      MFSD_HST_IDLE:
      begin
        if (req_i)
        begin
          next_r.kind  = req_kind_i;
          next_r.addr  = req_addr_i;
          next_r.wdata = req_wdata_i;
          next_r.state = MFSD_HST_DRIVE;
        end
      end
      MFSD_HST_DRIVE:
      begin
        next_r.state = MFSD_HST_SAMPLE;
      end
      MFSD_HST_SAMPLE:
      begin
        next_r.rdata    = bus.data_bus;
        next_r.answered = bus.dev_data_oe;
        next_r.done     = 1'b1;
        next_r.state    = MFSD_HST_FINISH;
      end
      MFSD_HST_FINISH:
      begin
        next_r.state = MFSD_HST_IDLE;
      end
      default:
      begin
        next_r.state = MFSD_HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      r.state    <= MFSD_HST_IDLE;
      r.kind     <= MFSD_KIND_READ;
      r.addr     <= 16'h0000;
      r.wdata    <= DATA_ZERO;
      r.rdata    <= DATA_ZERO;
      r.answered <= 1'b0;
      r.done     <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Only one strobe at a time, so the device never sees fetch and read together
  assign active           = (r.state == MFSD_HST_DRIVE) || (r.state == MFSD_HST_SAMPLE);
  assign bus.addr         = r.addr;
  assign bus.psen_n       = !(active && (r.kind == MFSD_KIND_FETCH));
  assign bus.rd_n         = !(active && (r.kind == MFSD_KIND_READ));
  assign bus.wr_n         = !(active && (r.kind == MFSD_KIND_WRITE));
  assign bus.host_data    = r.wdata;
  assign bus.host_data_oe = active && (r.kind == MFSD_KIND_WRITE);
  assign ready_o          = (r.state == MFSD_HST_IDLE);
  assign done_o           = r.done;
  assign rdata_o          = r.rdata;
  assign answered_o       = r.answered;

endmodule // mfsd_host

// file: verif/mfsd_props.sv
// Purpose: Wire-level checks between the host end and the device end
// Assumes: Map writes are seen on the shared data wire
// Notes:   Keeps its own copy of the map, so a map that never updates is caught
`timescale 1ns/100ps
module mfsd_props
  import mfsd_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [15:0] addr,
  input wire logic        psen_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        dev_data_oe,
  input wire logic [7:0]  data_bus
);
  logic [4:0] map_q;
  logic       in_ctrl;
  logic       in_sram;
  logic       in_sec;
  logic       in_main;

  // Raw decode: a denied higher target still hides the lower ones
  assign in_ctrl = addr >= CTRL_LOW;
  assign in_sram = addr >= SRAM_LOW && addr <= SRAM_HIGH;
  assign in_sec  = addr >= SEC_LOW0 && addr < 16'ha000;
  assign in_main = !(in_ctrl || in_sram || in_sec);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      map_q <= MAP_RESET[4:0];
    else if (!wr_n && addr == MAP_ADDR)
      map_q <= data_bus[4:0];
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_main_fetch; !psen_n && in_main |=> dev_data_oe == map_q[2]; endproperty
  property p_sec_fetch; !psen_n && in_sec |=> dev_data_oe == map_q[1]; endproperty
  property p_sram_fetch; !psen_n && in_sram |=> dev_data_oe == map_q[0]; endproperty
  property p_main_read; !rd_n && in_main |=> dev_data_oe == map_q[4]; endproperty
  property p_sec_read; !rd_n && in_sec |=> dev_data_oe == map_q[3]; endproperty
  property p_sram_read; !rd_n && in_sram |=> dev_data_oe; endproperty
  property p_ctrl_fetch; !psen_n && in_ctrl |=> !dev_data_oe; endproperty
  property p_write_quiet; !wr_n |=> !dev_data_oe [*2]; endproperty

  a_main_fetch: assert property (p_main_fetch) else $error("main fetch gating wrong");
  a_sec_fetch: assert property (p_sec_fetch) else $error("secondary fetch wrong");
  a_sram_fetch: assert property (p_sram_fetch) else $error("sram fetch wrong");
  a_main_read: assert property (p_main_read) else $error("main read gating wrong");
  a_sec_read: assert property (p_sec_read) else $error("secondary read wrong");
  a_sram_read: assert property (p_sram_read) else $error("sram read unanswered");
  a_ctrl_fetch: assert property (p_ctrl_fetch) else $error("fetch from control space");
  a_write_quiet: assert property (p_write_quiet) else $error("device drove on write");

  c_sram_read: cover property (!rd_n && in_sram);
  c_sec_fetch: cover property (!psen_n && in_sec && map_q[1]);
  c_map_write: cover property (!wr_n && addr == MAP_ADDR);
endmodule // mfsd_props

// file: verif/tb_memory_select_priority_decoder.sv
// Purpose: Self-checking bench joining the host end to the device end
// Assumes: One clock, synchronous reset
// Notes:   Expected selects come from a model of decode, priority and map
`timescale 1ns/100ps
module tb_memory_select_priority_decoder;
  import mfsd_pkg::*;
  typedef struct packed {
    logic       ans;
    logic       chk;
    logic [7:0] data;
    logic [7:0] main;
    logic [3:0] sec;
    logic       sram;
    logic       ctrl;
    logic [7:0] map;
  } mfsd_note_type;

  logic          clk_i;
  logic          reset_i;
  logic          req_i;
  mfsd_kind_type req_kind_i;
  logic [15:0]   req_addr_i;
  logic [7:0]    req_wdata_i;
  logic [7:0]    mem_rdata_i;
  logic          ready_o;
  logic          done_o;
  logic [7:0]    rdata_o;
  logic          answered_o;
  logic [7:0]    main_o;
  logic [3:0]    sec_o;
  logic          sram_o;
  logic          ctrl_o;
  logic [7:0]    map_o;
  logic [7:0]    map_m;
  mfsd_note_type notes[$];
  mfsd_note_type seen_n;
  int            failures = 0;
  int            check_count = 0;
  int            cycles = 0;
  logic [15:0]   addrs[7] = '{16'h0100, 16'h2100, 16'h3000, 16'h8900, 16'h9fff, 16'ha000,
                              16'hff10};
  logic [7:0]    maps[5] = '{8'h14, 8'h0b, 8'h1f, 8'h00, 8'h0c};

  mfsd_bus_if bus_if ();
  mfsd_host mfsd_host_inst (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if.host), .req_i(req_i),
    .req_kind_i(req_kind_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .answered_o(answered_o));
  mfsd_device mfsd_device_inst (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if.device),
    .mem_rdata_i(mem_rdata_i), .main_flash_sector_select_o(main_o),
    .secondary_flash_sector_select_o(sec_o), .sram_select_o(sram_o),
    .control_register_space_select_o(ctrl_o), .memory_space_map_o(map_o));
  mfsd_props mfsd_props_inst (.clk_i(clk_i), .reset_i(reset_i), .addr(bus_if.addr),
    .psen_n(bus_if.psen_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n),
    .dev_data_oe(bus_if.dev_data_oe), .data_bus(bus_if.data_bus));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Notes the expected answer, then runs one bus cycle through the host
  task automatic op(input mfsd_kind_type k, input logic [15:0] a, input logic [7:0] w);
    mfsd_note_type n;
    logic          ps;
    logic [7:0]    m;
    n = '0;
    ps = (k == MFSD_KIND_FETCH);
    m = 8'($urandom);
    if (a >= CTRL_LOW)
      n.ctrl = !ps;
    else if (a >= SRAM_LOW && a <= SRAM_HIGH)
      n.sram = ps ? map_m[0] : 1'b1;
    else if (a >= SEC_LOW0 && a < 16'ha000)
      n.sec[a[12:11]] = ps ? map_m[1] : map_m[3];
    else
      n.main[a[15:13]] = ps ? map_m[2] : map_m[4];
    n.chk = (k != MFSD_KIND_WRITE);
    n.ans = n.chk && (n.ctrl || n.sram || |n.sec || |n.main);
    n.data = !n.ans ? DATA_IDLE : !n.ctrl ? m : (a == MAP_ADDR) ? map_m : DATA_ZERO;
    if (k == MFSD_KIND_WRITE && a == MAP_ADDR)
      map_m = {3'b000, w[4:0]};
    n.map = map_m;
    // Note goes in only once the host is free, so the monitor sees one note per cycle
    while (ready_o !== 1'b1)
      @(negedge clk_i);
    notes.push_back(n);
    req_i = 1'b1;
    req_kind_i = k;
    req_addr_i = a;
    req_wdata_i = w;
    mem_rdata_i = m;
    @(negedge clk_i);
    req_i = 1'b0;
  endtask

  always @(negedge clk_i)
  begin
    if (done_o === 1'b1)
    begin
      check(notes.size(), 32'h1);
      seen_n = notes.pop_front();
      check(answered_o, seen_n.ans);
      if (seen_n.chk)
        check(rdata_o, seen_n.data);
      check({main_o, sec_o, sram_o, ctrl_o}, {seen_n.main, seen_n.sec, seen_n.sram,
        seen_n.ctrl});
      check(map_o, seen_n.map);
    end
  end

  // Some 171 bus cycles of four clocks each are expected
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    reset_i = 1'b1;
    req_i = 1'b0;
    req_kind_i = MFSD_KIND_FETCH;
    req_addr_i = 16'h0000;
    req_wdata_i = 8'h00;
    mem_rdata_i = 8'h00;
    map_m = MAP_RESET;
    void'($urandom(32'hf64560e0));
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    op(MFSD_KIND_READ, MAP_ADDR, 8'h00);
    foreach (maps[j])
    begin
      op(MFSD_KIND_WRITE, MAP_ADDR, maps[j]);
      foreach (addrs[i])
        for (int k = 0; k < 3; k++)
          op(mfsd_kind_type'(k), addrs[i], 8'(k));
    end
    // Random mix, upper map bits kept zero as software must
    for (int i = 0; i < 60; i++)
      op(mfsd_kind_type'($urandom % 3), ($urandom % 4 == 0) ? MAP_ADDR : 16'($urandom),
        8'($urandom) & 8'h1f);
    repeat (6) @(negedge clk_i);
    check(notes.size(), 32'h0);
    tally_and_finish();
  end
endmodule // tb_memory_select_priority_decoder
